// >>> bootstrap_params.svh
// Constants for the bootstrap init status and high/low-side coupling logic.
// Assumes a 50 MHz core clock and a host register port decoded upstream.
// Contract
// - Read-only status word, active-low charged flags 4..0
// - Reset: charged flags one, raised flags zero
// - Raised flag set when 1.0 V threshold needed
// - Uncharged plus raised means timer lapsed, 1.0 V
// - After charge, raised flag keeps finishing threshold
// - Bits 15..10 show timer top bits, reset zero
// - Timer field zero during gate supply undervoltage
// - Timer code advances with stable supply time
// - Code 110011 is last low-threshold code
// - Code 110100 final, 1.0 V threshold used
// - Expired timer shows final code 110100
// - Lockable link register, links reset one, disables zero
// - Partner signal high when linked low-side on
// - Disable bit forces partner signal high
// - Shared timer from supply good, raises at 36 ms
// - Raise sets flags of drivers still initializing
// - Partner signal high ends that driver's init
`ifndef BOOTSTRAP_PARAMS_SVH
`define BOOTSTRAP_PARAMS_SVH
`define CLK_MHZ         50
`define STATUS_ADDR     10'h1A5
`define LINK_ADDR       10'h1A6
`define LINK_RESET      16'h7F7F
`define LINK_GROUP_W    8
`define LINK_DIS_POS    7
`define CHG_LSB         0
`define RAISE_LSB       5
`define CODE_LSB        10
`define CODE_ZERO       6'h00
`define CODE_LAST_LOW   6'h33
`define CODE_FINAL      6'h34
`define CODE32_TIME_US  21800
`define EXPIRY_TIME_US  36000
`define TICK_CYCLES     ((`CODE32_TIME_US * `CLK_MHZ) / 32)
`define EXPIRY_CYCLES   (`EXPIRY_TIME_US * `CLK_MHZ)
`endif

// >>> bootstrap_pkg.sv
// Types shared by the bootstrap init logic.
// Assumes nothing beyond the constants header.
package bootstrap_pkg;
   typedef enum logic [1:0] {
      DRV_WAIT,
      DRV_LOW,
      DRV_HIGH,
      DRV_DONE
   } drv_state_t;
endpackage

// >>> init_if.sv
// Carrier between the shared init timer and the per-driver init machines.
// Assumes the top drives the supply flag.
`timescale 1ns/1ps
`default_nettype none
interface init_if;
   logic       gate_supply_undervolt;
   logic [5:0] timer_code;
   logic       expire_pulse;
   logic       expired;
   modport timer  (input gate_supply_undervolt, output timer_code, expire_pulse, expired);
   modport driver (input gate_supply_undervolt, input expire_pulse);
endinterface
`default_nettype wire

// >>> init_timer.sv
// Shared bootstrap initialization timer and its six-bit status code.
// Assumes the undervoltage flag is synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "bootstrap_params.svh"
module init_timer #(
   parameter int unsigned TICK_CYCLES   = `TICK_CYCLES,
   parameter int unsigned EXPIRY_CYCLES = `EXPIRY_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   init_if.timer    tmr
);
   logic [15:0] tick_q;
   logic [20:0] elap_q;
   logic [5:0]  code_q;
   logic        exp_q;
   logic        pulse_q;
   wire         uv       = tmr.gate_supply_undervolt;
   wire         tick_end = tick_q == 16'(TICK_CYCLES - 1);
   wire         elap_end = elap_q == 21'(EXPIRY_CYCLES - 1);
   wire         raise    = !uv && !exp_q && elap_end;
   wire [15:0]  tick_d   = (uv || tick_end) ? 16'h0000 : tick_q + 16'h0001;
   wire [20:0]  elap_d   = (uv || exp_q) ? 21'h000000 : elap_q + 21'h000001;
   // Code stops at the last low code until expiry so the final code always means 1.0 V
   wire         step     = tick_end && (code_q != `CODE_LAST_LOW);
   wire [5:0]   code_d   = uv ? `CODE_ZERO :
                           (exp_q || raise) ? `CODE_FINAL :
                           step ? code_q + 6'h01 : code_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q  <= 16'h0000;
         elap_q  <= 21'h000000;
         code_q  <= `CODE_ZERO;
         exp_q   <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         tick_q  <= tick_d;
         elap_q  <= elap_d;
         code_q  <= code_d;
         exp_q   <= !uv && (exp_q || elap_end);
         pulse_q <= raise;
      end
   end
   assign tmr.timer_code   = code_q;
   assign tmr.expired      = exp_q;
   assign tmr.expire_pulse = pulse_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   uv_code_zero_a: assert property (uv |=> code_q == 6'h00)
      else $error("timer code not zero in undervoltage");
   final_hold_a: assert property (exp_q && !uv |=> code_q == 6'h34 && exp_q)
      else $error("final timer code not held");
   code_step_a: assert property (!uv && !exp_q && !raise |=> code_q == $past(code_q) ||
                                 code_q == $past(code_q) + 6'h01)
      else $error("timer code jumped");
   low_cap_a: assert property (!exp_q |-> code_q <= 6'h33)
      else $error("final code shown before expiry");
   raise_code_a: assert property (pulse_q |-> code_q == 6'h34 && exp_q)
      else $error("expiry pulse without final code");
endmodule
`default_nettype wire

// >>> driver_init.sv
// Bootstrap init state machine for one high-side pre-driver.
// Assumes the charge comparator input is already qualified by the threshold in use.
`timescale 1ns/1ps
`default_nettype none
module driver_init (
   input  wire logic core_clk,
   input  wire logic rst_n,
   init_if.driver    ctl,
   input  wire logic charge_detect,
   input  wire logic lowside_active,
   input  wire logic highside_on,
   output var  logic cap_charged_n,
   output var  logic source_threshold_raised,
   output var  logic threshold_high,
   output var  logic in_init
);
   bootstrap_pkg::drv_state_t state_q;
   bootstrap_pkg::drv_state_t state_d;
   wire done_req = charge_detect || lowside_active || highside_on;
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         bootstrap_pkg::DRV_WAIT: begin
            if (!ctl.gate_supply_undervolt) state_d = bootstrap_pkg::DRV_LOW;
         end
         bootstrap_pkg::DRV_LOW: begin
            // Finishing wins over a same-cycle raise: charge was seen at 0.5 V
            if (done_req) state_d = bootstrap_pkg::DRV_DONE;
            else if (ctl.expire_pulse) state_d = bootstrap_pkg::DRV_HIGH;
         end
         bootstrap_pkg::DRV_HIGH: begin
            if (done_req) state_d = bootstrap_pkg::DRV_DONE;
         end
         bootstrap_pkg::DRV_DONE: begin
            state_d = bootstrap_pkg::DRV_DONE;
         end
      endcase
   end
   wire raise_now = (state_q == bootstrap_pkg::DRV_LOW) && (state_d == bootstrap_pkg::DRV_HIGH);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q                 <= bootstrap_pkg::DRV_WAIT;
         cap_charged_n           <= 1'b1;
         source_threshold_raised <= 1'b0;
         threshold_high          <= 1'b0;
         in_init                 <= 1'b0;
      end else begin
         state_q                 <= state_d;
         cap_charged_n           <= state_d != bootstrap_pkg::DRV_DONE;
         source_threshold_raised <= source_threshold_raised || raise_now;
         threshold_high          <= state_d == bootstrap_pkg::DRV_HIGH;
         in_init                 <= (state_d == bootstrap_pkg::DRV_LOW) ||
                                    (state_d == bootstrap_pkg::DRV_HIGH);
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wait_flags_a: assert property (state_q == bootstrap_pkg::DRV_WAIT |->
                                  cap_charged_n && !source_threshold_raised)
      else $error("flags wrong before init starts");
   raise_flag_a: assert property (state_q == bootstrap_pkg::DRV_LOW && ctl.expire_pulse &&
                                  !done_req |=> source_threshold_raised)
      else $error("raised flag not set at expiry");
   lapsed_thr_a: assert property (cap_charged_n && source_threshold_raised |->
                                  threshold_high)
      else $error("lapsed driver not at high threshold");
   charged_keep_a: assert property (!cap_charged_n |=> !cap_charged_n &&
                                    $stable(source_threshold_raised))
      else $error("charged record changed");
   partner_end_a: assert property (in_init && lowside_active |=> !in_init && !cap_charged_n)
      else $error("init not ended by partner");
endmodule
`default_nettype wire

// >>> bootstrap_status_top.sv
// Bootstrap init status register, high-side 1/2 low-side coupling register,
// shared init timer and five per-driver init machines.
// Assumes inputs synchronous to core_clk and a register port decoded from the serial host link.
`timescale 1ns/1ps
`default_nettype none
`include "bootstrap_params.svh"
module bootstrap_status_top #(
   parameter int unsigned TICK_CYCLES   = `TICK_CYCLES,
   parameter int unsigned EXPIRY_CYCLES = `EXPIRY_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        gate_supply_undervolt,
   input  wire logic [4:0]  charge_detect,
   input  wire logic [6:0]  lowside_on,
   input  wire logic [4:0]  highside_on,
   input  wire logic [2:0]  partner_on_ext,
   input  wire logic        lock_active,
   input  wire logic [9:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output var  logic [15:0] reg_rdata_q,
   output var  logic        reg_rvalid_q,
   output var  logic [4:0]  cap_charged_n,
   output var  logic [4:0]  source_threshold_raised,
   output var  logic [4:0]  threshold_high,
   output var  logic        init_active_q,
   output var  logic [1:0]  lowside_partner_on_q
);
   logic        rst_meta_q;
   logic        rst_n;
   logic [15:0] link_q;
   logic [4:0]  in_init;
   logic [1:0]  partner_d;
   // Release is synchronised so every flop leaves reset on the same edge
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end
   init_if ifc ();
   assign ifc.gate_supply_undervolt = gate_supply_undervolt;
   init_timer #(
      .TICK_CYCLES   (TICK_CYCLES),
      .EXPIRY_CYCLES (EXPIRY_CYCLES)
   ) u_timer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tmr      (ifc)
   );
   wire [4:0] partner_all = {partner_on_ext, lowside_partner_on_q};
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_drv
         driver_init u_drv (
            .core_clk                (core_clk),
            .rst_n                   (rst_n),
            .ctl                     (ifc),
            .charge_detect           (charge_detect[g]),
            .lowside_active          (partner_all[g]),
            .highside_on             (highside_on[g]),
            .cap_charged_n           (cap_charged_n[g]),
            .source_threshold_raised (source_threshold_raised[g]),
            .threshold_high          (threshold_high[g]),
            .in_init                 (in_init[g])
         );
      end
      for (g = 0; g < 2; g++) begin : g_link
         wire [6:0] sel = link_q[g*`LINK_GROUP_W +: 7];
         wire       dis = link_q[g*`LINK_GROUP_W + `LINK_DIS_POS];
         // Disable forces high so an unused driver leaves init at once
         assign partner_d[g] = dis || |(sel & lowside_on);
      end
   endgenerate
   wire        status_sel  = reg_addr == `STATUS_ADDR;
   wire        link_sel    = reg_addr == `LINK_ADDR;
   // Lock only blocks writes; the register stays readable
   wire        link_we     = reg_wr && link_sel && !lock_active;
   wire [15:0] link_d      = link_we ? reg_wdata : link_q;
   wire [5:0]  timer_code  = ifc.timer_code;
   wire [15:0] status_word = {timer_code, source_threshold_raised, cap_charged_n};
   // Status reads are pure selects, nothing is cleared on read
   wire [15:0] read_word   = status_sel ? status_word :
                             link_sel ? link_q : 16'h0000;
   wire [15:0] rdata_d     = reg_rd ? read_word : reg_rdata_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_q               <= `LINK_RESET;
         reg_rdata_q          <= 16'h0000;
         reg_rvalid_q         <= 1'b0;
         init_active_q        <= 1'b0;
         lowside_partner_on_q <= 2'h0;
      end else begin
         link_q               <= link_d;
         reg_rdata_q          <= rdata_d;
         reg_rvalid_q         <= reg_rd;
         init_active_q        <= |in_init;
         lowside_partner_on_q <= partner_d;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   status_read_a: assert property (reg_rd && status_sel |=> reg_rvalid_q &&
                                   reg_rdata_q == $past(status_word))
      else $error("status read data wrong");
   timer_field_a: assert property (reg_rd && status_sel |=>
                                   reg_rdata_q[15:10] == $past(timer_code))
      else $error("timer field wrong in status read");
   link_write_a: assert property (reg_wr && link_sel && !lock_active |=>
                                  link_q == $past(reg_wdata))
      else $error("link write not stored");
   link_lock_a: assert property (reg_wr && lock_active |=> $stable(link_q))
      else $error("locked link register changed");
   partner_on_a: assert property (|(link_q[6:0] & lowside_on) |=>
                                  lowside_partner_on_q[0])
      else $error("high-side one partner not seen");
   link_dis_a: assert property (link_q[15] && $past(link_q[15]) |->
                                lowside_partner_on_q[1])
      else $error("disabled link not forced high");
   partner_idle_a: assert property (!link_q[7] && !(|(link_q[6:0] & lowside_on)) |=>
                                    !lowside_partner_on_q[0])
      else $error("partner high without cause");
   unmapped_a: assert property (reg_rd && !status_sel && !link_sel |=>
                                reg_rdata_q == 16'h0000)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

// >>> host_port.sv
// Host model driving the parallel register port with single-word reads and writes.
// Assumes the bench calls its tasks and that inputs are sampled on core_clk rising edges.
`timescale 1ns/1ps
`default_nettype none
module host_port (
   input  wire logic        core_clk,
   input  wire logic [15:0] reg_rdata_q,
   input  wire logic        reg_rvalid_q,
   output var  logic [9:0]  reg_addr,
   output var  logic        reg_wr,
   output var  logic        reg_rd,
   output var  logic [15:0] reg_wdata
);
   initial begin
      reg_addr  = 10'h000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 16'h0000;
   end
   // The caller picks which low-sides share a load; this only carries the word
   task automatic write_reg(input logic [9:0] a, input logic [15:0] d);
      @(negedge core_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr    = 1'b0;
      // Released bus shows inverted values so stale data cannot pass
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask
   task automatic read_reg(input logic [9:0] a, output logic [15:0] d);
      d = 16'hXXXX;
      @(negedge core_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      // Valid stands for one cycle only, so take the data before the strobe drops
      if (reg_rvalid_q === 1'b1) begin
         d = reg_rdata_q;
      end
      reg_rd   = 1'b0;
      reg_addr = ~a;
   endtask
endmodule
`default_nettype wire

// >>> bootstrap_status_top_tb.sv
// Self-checking bench for the bootstrap status and coupling block.
// Assumes a shortened timer: 4 cycles per code step, expiry after 220 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "bootstrap_params.svh"
module bootstrap_status_top_tb;
   logic        core_clk;
   logic        resetn;
   logic        gate_supply_undervolt;
   logic        lock_active;
   logic [4:0]  charge_detect;
   logic [6:0]  lowside_on;
   logic [4:0]  highside_on;
   logic [2:0]  partner_on_ext;
   logic [9:0]  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata_q;
   logic        reg_rvalid_q;
   logic [4:0]  cap_charged_n;
   logic [4:0]  source_threshold_raised;
   logic [4:0]  threshold_high;
   logic        init_active_q;
   logic [1:0]  lowside_partner_on_q;
   logic [15:0] rd;
   int          bad_count;
   int          checks;
   bootstrap_status_top #(.TICK_CYCLES(4), .EXPIRY_CYCLES(220)) i_bootstrap_status_top (
      .core_clk, .resetn, .gate_supply_undervolt, .charge_detect, .lowside_on,
      .highside_on, .partner_on_ext, .lock_active, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .cap_charged_n, .source_threshold_raised,
      .threshold_high, .init_active_q, .lowside_partner_on_q);
   host_port i_host_port (.core_clk, .reg_rdata_q, .reg_rvalid_q, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata);
   task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_flags(input string what, input logic [4:0] exp, input logic [4:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_pair(input string what, input logic [1:0] exp, input logic [1:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("Counts: %0d comparisons, %0d mismatches", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      i_host_port.read_reg(`STATUS_ADDR, rd);
      chk_word("status after reset", {`CODE_ZERO, 5'h00, 5'h1F}, rd);
      i_host_port.read_reg(`LINK_ADDR, rd);
      chk_word("link after reset", `LINK_RESET, rd);
      i_host_port.read_reg(10'h3FF, rd);
      chk_word("unmapped read", 16'h0000, rd);
      chk_pair("partner after reset", 2'b00, lowside_partner_on_q);
      $display("t_reset done");
   endtask
   task automatic t_timer;
      @(negedge core_clk);
      gate_supply_undervolt = 1'b0;
      repeat (4) @(negedge core_clk);
      i_host_port.read_reg(`STATUS_ADDR, rd);
      chk_word("first code step", {6'h01, 5'h00, 5'h1F}, rd);
      chk_bit("init active", 1'b1, init_active_q);
      charge_detect[0] = 1'b1;
      repeat (3) @(negedge core_clk);
      charge_detect[0] = 1'b0;
      repeat (3) @(negedge core_clk);
      chk_flags("charged latch", 5'h1E, cap_charged_n);
      chk_flags("raised at low", 5'h00, source_threshold_raised);
      repeat (195) @(negedge core_clk);
      i_host_port.read_reg(`STATUS_ADDR, rd);
      chk_word("last low code", {`CODE_LAST_LOW, 5'h00, 5'h1E}, rd);
      repeat (20) @(negedge core_clk);
      i_host_port.read_reg(`STATUS_ADDR, rd);
      chk_word("expired status", {`CODE_FINAL, 5'h1E, 5'h1E}, rd);
      chk_flags("high threshold", 5'h1E, threshold_high);
      $display("t_timer done");
   endtask
   task automatic t_ends;
      charge_detect[1] = 1'b1;
      highside_on[2]   = 1'b1;
      partner_on_ext[1] = 1'b1;
      repeat (4) @(negedge core_clk);
      chk_flags("raised kept", 5'h1E, source_threshold_raised);
      repeat (30) @(negedge core_clk);
      i_host_port.read_reg(`STATUS_ADDR, rd);
      chk_word("final held", {`CODE_FINAL, 5'h1E, 5'h10}, rd);
      i_host_port.write_reg(`STATUS_ADDR, 16'h0000);
      i_host_port.read_reg(`STATUS_ADDR, rd);
      chk_word("status read only", {`CODE_FINAL, 5'h1E, 5'h10}, rd);
      gate_supply_undervolt = 1'b1;
      repeat (3) @(negedge core_clk);
      i_host_port.read_reg(`STATUS_ADDR, rd);
      chk_word("undervolt code", {`CODE_ZERO, 5'h1E, 5'h10}, rd);
      gate_supply_undervolt = 1'b0;
      $display("t_ends done");
   endtask
   task automatic t_coupling;
      i_host_port.write_reg(`LINK_ADDR, 16'h0102);
      lowside_on = 7'h02;
      repeat (2) @(negedge core_clk);
      chk_pair("hs1 linked", 2'b01, lowside_partner_on_q);
      lowside_on = 7'h01;
      repeat (2) @(negedge core_clk);
      chk_pair("hs2 linked", 2'b10, lowside_partner_on_q);
      lowside_on = 7'h7C;
      repeat (2) @(negedge core_clk);
      chk_pair("unlinked", 2'b00, lowside_partner_on_q);
      lock_active = 1'b1;
      i_host_port.write_reg(`LINK_ADDR, 16'hFFFF);
      i_host_port.read_reg(`LINK_ADDR, rd);
      chk_word("locked write", 16'h0102, rd);
      lock_active = 1'b0;
      i_host_port.write_reg(`LINK_ADDR, 16'h8000);
      lowside_on = 7'h00;
      repeat (2) @(negedge core_clk);
      chk_pair("disable forces", 2'b10, lowside_partner_on_q);
      partner_on_ext[2] = 1'b1;
      repeat (4) @(negedge core_clk);
      chk_flags("all charged", 5'h00, cap_charged_n);
      chk_bit("init over", 1'b0, init_active_q);
      $display("t_coupling done");
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      bad_count++;
      finish_test();
   end
   initial begin
      resetn = 1'b0;
      gate_supply_undervolt = 1'b1;
      lock_active = 1'b0;
      charge_detect = 5'h00;
      lowside_on = 7'h00;
      highside_on = 5'h00;
      partner_on_ext = 3'h0;
      bad_count = 0;
      checks = 0;
      repeat (16) @(negedge core_clk);
      resetn = 1'b1;
      repeat (3) @(negedge core_clk);
      t_reset();
      t_timer();
      t_ends();
      t_coupling();
      finish_test();
   end
endmodule
`default_nettype wire
